// ### axil_slave.sv
`timescale 1ns/10ps
`include "cin_consts.svh"

// AXI4-Lite slave that turns bus traffic into register strobes.
module axil_slave (
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic [7:0]  s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	input  wire logic [7:0]  s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready,
	output cin_pkg::wreq_t   wr,
	input  wire logic        wr_ok,
	output logic             rd_en,
	output logic [7:0]       rd_addr,
	input  wire logic [31:0] rd_data,
	input  wire logic        rd_ok
);

	// ---------------------------------------------------------------
	// Write path
	// ---------------------------------------------------------------
	logic [7:0]  aw_addr_q;  // Held write address.
	logic        aw_full_q;  // Write address captured.
	logic [31:0] w_data_q;   // Held write data.
	logic [3:0]  w_strb_q;   // Held byte enables.
	logic        w_full_q;   // Write data captured.
	wire         aw_hs;      // Address handshake.
	wire         w_hs;       // Data handshake.
	wire         do_wr;      // Both halves present, commit now.

	assign aw_hs   = s_awvalid & s_awready;
	assign w_hs    = s_wvalid & s_wready;
	assign do_wr   = aw_full_q & w_full_q & ~s_bvalid;
	assign wr.en   = do_wr;
	assign wr.addr = aw_addr_q;
	assign wr.data = w_data_q;
	assign wr.strb = w_strb_q;

	// Address and data are taken in either order, once per write.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			aw_addr_q <= 8'h00;
			aw_full_q <= 1'b0;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			w_full_q  <= 1'b0;
			s_awready <= 1'b1;
			s_wready  <= 1'b1;
			s_bvalid  <= 1'b0;
			s_bresp   <= `CIN_RESP_OKAY;
		end else begin
			if (aw_hs) begin
				aw_addr_q <= s_awaddr;
				aw_full_q <= 1'b1;
				s_awready <= 1'b0;
			end
			if (w_hs) begin
				w_data_q <= s_wdata;
				w_strb_q <= s_wstrb;
				w_full_q <= 1'b1;
				s_wready <= 1'b0;
			end
			if (do_wr) begin
				aw_full_q <= 1'b0;
				w_full_q  <= 1'b0;
				s_bvalid  <= 1'b1;
				s_bresp   <= wr_ok ? `CIN_RESP_OKAY : `CIN_RESP_SLVERR;
			end else if (s_bvalid && s_bready) begin
				s_bvalid  <= 1'b0;
				s_awready <= 1'b1;
				s_wready  <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// Read path
	// ---------------------------------------------------------------
	assign rd_en   = s_arvalid & s_arready;
	assign rd_addr = s_araddr;

	// Data is sampled at the address handshake and held until taken.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			s_arready <= 1'b1;
			s_rvalid  <= 1'b0;
			s_rdata   <= 32'h0000_0000;
			s_rresp   <= `CIN_RESP_OKAY;
		end else if (rd_en) begin
			s_arready <= 1'b0;
			s_rvalid  <= 1'b1;
			s_rdata   <= rd_ok ? rd_data : 32'h0000_0000;
			s_rresp   <= rd_ok ? `CIN_RESP_OKAY : `CIN_RESP_SLVERR;
		end else if (s_rvalid && s_rready) begin
			s_rvalid  <= 1'b0;
			s_arready <= 1'b1;
		end
	end

endmodule : axil_slave

// ### cin_consts.svh
`ifndef CIN_CONSTS_SVH
`define CIN_CONSTS_SVH

// ---------------------------------------------------------------
// Sizes and timing
// ---------------------------------------------------------------
`define CIN_NUM_INPUTS      16
`define CIN_CLK_MHZ         200
`define CIN_TICK_MS         10
`define CIN_TICK_CYCLES     (`CIN_TICK_MS * 1000 * `CIN_CLK_MHZ)
`define CIN_DELAY_MAX_S     60
`define CIN_DELAY_MAX_TICKS (`CIN_DELAY_MAX_S * 1000 / `CIN_TICK_MS)
`define CIN_AC_HOLD_TICKS   2'h2

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define CIN_ADDR_CTRL       8'h00
`define CIN_ADDR_STATE      8'h04
`define CIN_ADDR_POLARITY   8'h08
`define CIN_ADDR_ON_EN      8'h0c
`define CIN_ADDR_OFF_EN     8'h10
`define CIN_ADDR_POPUP_EN   8'h14
`define CIN_ADDR_LATCH_SEL  8'h18
`define CIN_ADDR_EVT_STAT   8'h1c
`define CIN_ADDR_EVT_MASK   8'h20
`define CIN_ADDR_POPUP_STAT 8'h24
`define CIN_ADDR_ROUTE      8'h28
`define CIN_ADDR_DELAY_BASE 8'h40
`define CIN_ADDR_COUNT_BASE 8'h80

// ---------------------------------------------------------------
// Control register fields and reset values
// ---------------------------------------------------------------
`define CIN_CTRL_AC_BIT     0
`define CIN_CTRL_REL_BIT    1
`define CIN_CTRL_RELIN_BIT  2
`define CIN_CTRL_IDX_LSB    4
`define CIN_CTRL_IDX_MSB    7
`define CIN_RST_WORD        32'h0000_0000
`define CIN_RST_DELAY       13'h0000
`define CIN_RST_COUNT       16'h0000

// ---------------------------------------------------------------
// AXI responses
// ---------------------------------------------------------------
`define CIN_RESP_OKAY       2'h0
`define CIN_RESP_SLVERR     2'h2

`endif

// ### cin_pkg.sv
package cin_pkg;

	// Per-input configuration handed to each filter.
	typedef struct packed {
		logic        ac;       // Common ac energisation mode.
		logic        pol_nc;   // 1 means closed at rest.
		logic [12:0] delay;    // Qualification delay in 10 ms ticks.
	} chan_cfg_t;

	// One-cycle edge pulses of a conditioned input.
	typedef struct packed {
		logic act;             // Active edge taken.
		logic inact;           // Inactive edge taken.
	} edge_t;

	// Register write request from the bus slave.
	typedef struct packed {
		logic        en;       // One-cycle write strobe.
		logic [7:0]  addr;     // Byte address.
		logic [31:0] data;     // Write data.
		logic [3:0]  strb;     // Byte enables.
	} wreq_t;

endpackage : cin_pkg

// ### contact_field.sv
`timescale 1ns/10ps
// Field contacts behind threshold detectors; the detected level
// settles one clock after the contact moves.
module contact_field (
	input  wire logic        clk_sys,
	input  wire logic [15:0] close_cmd,
	output logic      [15:0] raw
);
	// A short drop stands for an ac half cycle; ac mode is set first.
	always @(posedge clk_sys) raw <= close_cmd;
endmodule : contact_field

// ### contact_filter.sv
`timescale 1ns/10ps
`include "cin_consts.svh"

// Qualifies one synchronised contact level into a conditioned state.
module contact_filter (
	input  wire logic              clk_sys,
	input  wire logic              rst_b,
	input  wire logic              tick,
	input  wire logic              raw,
	input  wire cin_pkg::chan_cfg_t cfg,
	output logic                   state_q,
	output cin_pkg::edge_t         edge_q
);

	// ---------------------------------------------------------------
	// Level shaping
	// ---------------------------------------------------------------
	logic [1:0]  hold_q;     // Ac stretch counter in ticks.
	logic [12:0] cnt_q;      // Ticks the level has differed.
	wire         eff;        // Level after ac stretching.
	wire         act_lvl;    // Level in active sense.
	wire         differ;     // Qualified state disagrees with level.
	wire [12:0]  cnt_inc;    // Tick count plus one.
	wire         expire;     // Level held for the full delay.

	// An ac-fed detector drops out each half cycle, so hold it high.
	assign eff     = raw | (cfg.ac && (hold_q != 2'h0));
	// Closed-at-rest inverts the sense, so a falling edge is active.
	assign act_lvl = eff ^ cfg.pol_nc;
	assign differ  = act_lvl != state_q;
	assign cnt_inc = cnt_q + 13'h0001;
	// The same delay serves both directions; zero passes at once.
	assign expire  = differ && ((cfg.delay == 13'h0000) ||
		(tick && (cnt_inc >= cfg.delay)));

	// The ac stretch reloads on every high sample.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			hold_q <= 2'h0;
		end else if (raw) begin
			hold_q <= `CIN_AC_HOLD_TICKS;
		end else if (tick && (hold_q != 2'h0)) begin
			hold_q <= hold_q - 2'h1;
		end
	end

	// ---------------------------------------------------------------
	// Qualification timer
	// ---------------------------------------------------------------
	// Any return to the old level restarts the stability count.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			cnt_q <= 13'h0000;
		end else if (!differ || expire) begin
			cnt_q <= 13'h0000;
		end else if (tick) begin
			cnt_q <= cnt_inc;
		end
	end

	// The state moves and reports the edge it took.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			state_q <= 1'b0;
			edge_q  <= '0;
		end else begin
			state_q <= expire ? act_lvl : state_q;
			edge_q.act   <= expire & act_lvl;
			edge_q.inact <= expire & ~act_lvl;
		end
	end

endmodule : contact_filter

// ### contact_input_conditioner.sv
// How it works
// - Sixteen inputs, each with own settings.
// - Conditioned state reads 1 active, 0 inactive.
// - Open at rest: rising edge is active.
// - Closed at rest: falling edge is active.
// - One delay, up to sixty seconds, both directions.
// - Enabled active edge raises an event.
// - Separately enabled inactive edge raises event.
// - Pop-up setting requests alarm on active edge.
// - Sixteen-bit active-edge counter, writable by software.
// - Common ac or dc mode for inputs.
// - States route to outputs, latched or unlatched.
// - Unlatched follows; latched holds after release.
// - One common release clears all latched outputs.
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/10ps
`include "cin_consts.svh"

module contact_input_conditioner #(
	parameter int unsigned TICK_CYCLES = `CIN_TICK_CYCLES
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic [15:0] contact_input_raw,
	input  wire logic        release_in,
	input  wire logic [7:0]  s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	input  wire logic [7:0]  s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready,
	output logic [15:0]      contact_input_state_q,
	output logic [15:0]      route_q,
	output logic             popup_q,
	output logic             irq_q
);

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// Merges a write word into an old word under byte enables.
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = data[8*b +: 8];
			end
		end
		return res;
	endfunction : merge

	// Tells whether an address falls in a sixteen-word array window.
	function automatic logic in_array(input logic [7:0] addr,
		input logic [7:0] base);
		return (addr[7:6] == base[7:6]) && (addr[1:0] == 2'h0);
	endfunction : in_array

	// ---------------------------------------------------------------
	// Bus slave
	// ---------------------------------------------------------------
	cin_pkg::wreq_t wr;        // Write strobe and payload.
	logic           wr_ok;     // Write address is mapped and writable.
	logic           rd_en;     // Read strobe.
	logic [7:0]     rd_addr;   // Read address.
	logic [31:0]    rd_data;   // Selected read word.
	logic           rd_ok;     // Read address is mapped.

	axil_slave u_bus (
		.clk_sys   (clk_sys),
		.rst_b     (rst_b),
		.s_awaddr  (s_awaddr),
		.s_awvalid (s_awvalid),
		.s_awready (s_awready),
		.s_wdata   (s_wdata),
		.s_wstrb   (s_wstrb),
		.s_wvalid  (s_wvalid),
		.s_wready  (s_wready),
		.s_bresp   (s_bresp),
		.s_bvalid  (s_bvalid),
		.s_bready  (s_bready),
		.s_araddr  (s_araddr),
		.s_arvalid (s_arvalid),
		.s_arready (s_arready),
		.s_rdata   (s_rdata),
		.s_rresp   (s_rresp),
		.s_rvalid  (s_rvalid),
		.s_rready  (s_rready),
		.wr        (wr),
		.wr_ok     (wr_ok),
		.rd_en     (rd_en),
		.rd_addr   (rd_addr),
		.rd_data   (rd_data),
		.rd_ok     (rd_ok)
	);

	// ---------------------------------------------------------------
	// Input synchronisers and tick divider
	// ---------------------------------------------------------------
	logic [16:0] sync1_q;     // First stage, read only by stage two.
	logic [16:0] sync2_q;     // Stable copy of pins and release.
	logic [20:0] tick_cnt_q;  // Cycles within one 10 ms tick.
	logic        tick_q;      // One-cycle 10 ms enable.

	// Two flip-flops tame the asynchronous pins.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			sync1_q <= 17'h00000;
			sync2_q <= 17'h00000;
		end else begin
			sync1_q <= {release_in, contact_input_raw};
			sync2_q <= sync1_q;
		end
	end

	// The divider issues the tick that paces every delay.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			tick_cnt_q <= 21'h000000;
			tick_q     <= 1'b0;
		end else if (tick_cnt_q == 21'(TICK_CYCLES - 1)) begin
			tick_cnt_q <= 21'h000000;
			tick_q     <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 21'h000001;
			tick_q     <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Configuration registers
	// ---------------------------------------------------------------
	logic [31:0] ctrl_q;       // Mode, release and release source.
	logic [15:0] pol_q;        // Closed-at-rest selection.
	logic [15:0] on_en_q;      // Active edge event enables.
	logic [15:0] off_en_q;     // Inactive edge event enables.
	logic [15:0] popup_en_q;   // Alarm pop-up enables.
	logic [15:0] latch_q;      // Latched routing selection.
	logic [31:0] evt_mask_q;   // Interrupt mask, status layout.
	logic [12:0] delay_q [16]; // Per-input delay in ticks.
	wire  [31:0] wmerge;       // Merged write word, by address.
	wire  [12:0] delay_wr;     // Clamped delay from a write.
	wire  [3:0]  wr_idx;       // Array index of a write.
	wire         wr_delay;     // Write hits the delay array.
	wire         wr_count;     // Write hits the counter array.

	assign wr_idx   = wr.addr[5:2];
	assign wr_delay = wr.en && in_array(wr.addr, `CIN_ADDR_DELAY_BASE);
	assign wr_count = wr.en && in_array(wr.addr, `CIN_ADDR_COUNT_BASE);
	assign wmerge   = merge(rd_word(wr.addr), wr.data, wr.strb);
	// Values past sixty seconds are held at the ceiling.
	assign delay_wr = (wmerge > 32'(`CIN_DELAY_MAX_TICKS)) ?
		13'(`CIN_DELAY_MAX_TICKS) : wmerge[12:0];

	// The release request bit is a pulse and never stays set.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			ctrl_q     <= `CIN_RST_WORD;
			pol_q      <= 16'h0000;
			on_en_q    <= 16'h0000;
			off_en_q   <= 16'h0000;
			popup_en_q <= 16'h0000;
			latch_q    <= 16'h0000;
			evt_mask_q <= `CIN_RST_WORD;
		end else begin
			ctrl_q[`CIN_CTRL_REL_BIT] <= 1'b0;
			if (wr.en) begin
				case (wr.addr)
					`CIN_ADDR_CTRL:      ctrl_q     <= wmerge & 32'h0000_00f7;
					`CIN_ADDR_POLARITY:  pol_q      <= wmerge[15:0];
					`CIN_ADDR_ON_EN:     on_en_q    <= wmerge[15:0];
					`CIN_ADDR_OFF_EN:    off_en_q   <= wmerge[15:0];
					`CIN_ADDR_POPUP_EN:  popup_en_q <= wmerge[15:0];
					`CIN_ADDR_LATCH_SEL: latch_q    <= wmerge[15:0];
					`CIN_ADDR_EVT_MASK:  evt_mask_q <= wmerge;
					default:             ctrl_q[`CIN_CTRL_REL_BIT] <= 1'b0;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Per-input channels
	// ---------------------------------------------------------------
	logic [15:0]    state;     // Conditioned states.
	cin_pkg::edge_t edges [16]; // Edge pulses per input.
	logic [15:0]    act_e;     // Active edge pulses.
	logic [15:0]    inact_e;   // Inactive edge pulses.
	logic [15:0]    cnt_q [16]; // Active edge counters.

	genvar gi;
	generate
		for (gi = 0; gi < `CIN_NUM_INPUTS; gi++) begin : g_ch
			cin_pkg::chan_cfg_t cfg; // Settings for this input.

			assign cfg.ac     = ctrl_q[`CIN_CTRL_AC_BIT];
			assign cfg.pol_nc = pol_q[gi];
			assign cfg.delay  = delay_q[gi];
			assign act_e[gi]   = edges[gi].act;
			assign inact_e[gi] = edges[gi].inact;

			// Each input keeps its own timer and state.
			contact_filter u_filt (
				.clk_sys (clk_sys),
				.rst_b   (rst_b),
				.tick    (tick_q),
				.raw     (sync2_q[gi]),
				.cfg     (cfg),
				.state_q (state[gi]),
				.edge_q  (edges[gi])
			);

			// Delay store, written by software only.
			always_ff @(posedge clk_sys) begin
				if (!rst_b) begin
					delay_q[gi] <= `CIN_RST_DELAY;
				end else if (wr_delay && (wr_idx == 4'(gi))) begin
					delay_q[gi] <= delay_wr;
				end
			end

			// A software preset wins; the count wraps past its top.
			always_ff @(posedge clk_sys) begin
				if (!rst_b) begin
					cnt_q[gi] <= `CIN_RST_COUNT;
				end else if (wr_count && (wr_idx == 4'(gi))) begin
					cnt_q[gi] <= wmerge[15:0];
				end else if (act_e[gi]) begin
					cnt_q[gi] <= cnt_q[gi] + 16'h0001;
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// Events, pop-up requests and interrupt
	// ---------------------------------------------------------------
	logic [31:0] evt_stat_q;   // Off edges high half, on edges low.
	logic [15:0] popup_stat_q; // Pending alarm pop-up requests.
	wire  [31:0] evt_set;      // New events this cycle.
	wire  [15:0] popup_set;    // New pop-up requests this cycle.
	wire  [31:0] evt_d;        // Next event status.
	wire  [15:0] popup_d;      // Next pop-up status.
	wire         rd_evt;       // Event status is being read.
	wire         rd_popup;     // Pop-up status is being read.

	// The counter wrap has no path into the event set.
	assign evt_set   = {inact_e & off_en_q, act_e & on_en_q};
	assign popup_set = act_e & popup_en_q;
	assign rd_evt    = rd_en && (rd_addr == `CIN_ADDR_EVT_STAT);
	assign rd_popup  = rd_en && (rd_addr == `CIN_ADDR_POPUP_STAT);
	// A read clears, but an edge in the same cycle survives it.
	assign evt_d     = (rd_evt ? 32'h0000_0000 : evt_stat_q) | evt_set;
	assign popup_d   = (rd_popup ? 16'h0000 : popup_stat_q) | popup_set;

	// Sticky status and the outputs gated from it.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			evt_stat_q   <= `CIN_RST_WORD;
			popup_stat_q <= 16'h0000;
			irq_q        <= 1'b0;
			popup_q      <= 1'b0;
		end else begin
			evt_stat_q   <= evt_d;
			popup_stat_q <= popup_d;
			irq_q        <= |(evt_d & evt_mask_q);
			popup_q      <= |popup_d;
		end
	end

	// ---------------------------------------------------------------
	// Output routing with latches
	// ---------------------------------------------------------------
	wire        rel_input;     // Release taken from a chosen input.
	wire        release_all;   // Common release of every latch.
	wire [15:0] route_d;       // Next routed outputs.

	assign rel_input   = ctrl_q[`CIN_CTRL_RELIN_BIT] &&
		state[ctrl_q[`CIN_CTRL_IDX_MSB:`CIN_CTRL_IDX_LSB]];
	assign release_all = ctrl_q[`CIN_CTRL_REL_BIT] | rel_input |
		sync2_q[16];
	// A latched output holds until release; an active input wins.
	assign route_d = (latch_q & ((route_q & {16{~release_all}}) | state)) |
		(~latch_q & state);

	// Routed and plain states leave through flip-flops.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			route_q               <= 16'h0000;
			contact_input_state_q <= 16'h0000;
		end else begin
			route_q               <= route_d;
			contact_input_state_q <= state;
		end
	end

	// ---------------------------------------------------------------
	// Read selection
	// ---------------------------------------------------------------
	// Returns the stored word at an address, zero when unmapped.
	function automatic logic [31:0] rd_word(input logic [7:0] a);
		logic [31:0] res;
		res = 32'h0000_0000;
		if (in_array(a, `CIN_ADDR_DELAY_BASE)) begin
			res = {19'h00000, delay_q[a[5:2]]};
		end else if (in_array(a, `CIN_ADDR_COUNT_BASE)) begin
			res = {16'h0000, cnt_q[a[5:2]]};
		end else begin
			case (a)
				`CIN_ADDR_CTRL:       res = ctrl_q;
				`CIN_ADDR_STATE:      res = {16'h0000, state};
				`CIN_ADDR_POLARITY:   res = {16'h0000, pol_q};
				`CIN_ADDR_ON_EN:      res = {16'h0000, on_en_q};
				`CIN_ADDR_OFF_EN:     res = {16'h0000, off_en_q};
				`CIN_ADDR_POPUP_EN:   res = {16'h0000, popup_en_q};
				`CIN_ADDR_LATCH_SEL:  res = {16'h0000, latch_q};
				`CIN_ADDR_EVT_STAT:   res = evt_stat_q;
				`CIN_ADDR_EVT_MASK:   res = evt_mask_q;
				`CIN_ADDR_POPUP_STAT: res = {16'h0000, popup_stat_q};
				`CIN_ADDR_ROUTE:      res = {16'h0000, route_q};
				default:              res = 32'h0000_0000;
			endcase
		end
		return res;
	endfunction : rd_word

	// Tells whether an address names a register.
	function automatic logic mapped(input logic [7:0] a);
		return in_array(a, `CIN_ADDR_DELAY_BASE) ||
			in_array(a, `CIN_ADDR_COUNT_BASE) ||
			((a <= `CIN_ADDR_ROUTE) && (a[1:0] == 2'h0));
	endfunction : mapped

	assign rd_data = rd_word(rd_addr);
	assign rd_ok   = mapped(rd_addr);
	// Status, state and routing words are read-only.
	assign wr_ok   = mapped(wr.addr) &&
		(wr.addr != `CIN_ADDR_STATE) &&
		(wr.addr != `CIN_ADDR_EVT_STAT) &&
		(wr.addr != `CIN_ADDR_POPUP_STAT) &&
		(wr.addr != `CIN_ADDR_ROUTE);

endmodule : contact_input_conditioner

// ### contact_input_conditioner_sva.sv
`timescale 1ns/10ps
// Checks at the pins of the conditioner.
module cin_checker (
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        s_awvalid,
	input  wire logic        s_awready,
	input  wire logic        s_wvalid,
	input  wire logic        s_wready,
	input  wire logic        s_bvalid,
	input  wire logic        s_bready,
	input  wire logic        s_arvalid,
	input  wire logic        s_arready,
	input  wire logic        s_rvalid,
	input  wire logic        s_rready,
	input  wire logic        popup_q,
	input  wire logic        irq_q,
	input  wire logic [7:0]  s_araddr,
	input  wire logic [31:0] s_rdata,
	input  wire logic [15:0] contact_input_state_q,
	input  wire logic [15:0] route_q
);
	// A taken read of the pop-up status word.
	wire pop_rd = s_arvalid && s_arready && s_araddr == 8'h24;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	out_reset_a: assert property (
		$rose(rst_b) |-> !contact_input_state_q && !route_q && !irq_q)
		else $error("outputs not clear after reset");
	b_hold_a: assert property (s_bvalid && !s_bready |=> s_bvalid)
		else $error("bvalid dropped");
	r_hold_a: assert property (s_rvalid && !s_rready |=> $stable(s_rdata))
		else $error("rdata changed");
	r_lat_a: assert property (s_arvalid && s_arready |=> s_rvalid)
		else $error("read answer late");
	b_lat_a: assert property (s_awvalid && s_awready && s_wvalid
		&& s_wready |-> ##[1:2] s_bvalid) else $error("write answer late");
	w_block_a: assert property (s_wvalid && s_wready |=> !s_wready)
		else $error("second write taken");
	pop_cause_a: assert property ($rose(popup_q) |->
		contact_input_state_q != $past(contact_input_state_q, 2))
		else $error("pop-up without an input change");
	pop_clear_a: assert property ($fell(popup_q) |->
		$past(pop_rd) || $past(pop_rd, 2)) else $error("pop-up lost");
	cover property ($rose(irq_q));
	cover property ($rose(popup_q));
	cover property (route_q != contact_input_state_q);
endmodule : cin_checker
bind contact_input_conditioner cin_checker chk_i (.*);

// ### contact_input_conditioner_tb.sv
`timescale 1ns/10ps
module contact_input_conditioner_tb;
	logic        clk_sys = 0, rst_b = 0, release_in = 0, awv = 0, wv = 0;
	logic        bready = 0, arv = 0, rready = 0, awr, wrr, bv, arr, rv;
	logic        pop, irq;
	logic [7:0]  awa = 0, ara = 0;
	logic [31:0] wd = 0, rd;
	logic [1:0]  br, rr;
	logic [15:0] lvl = 0, raw, st, rt;
	int          bad_count = 0, total_checks = 0, cyc = 0;
	contact_field field (.clk_sys, .close_cmd(lvl), .raw);
	contact_input_conditioner #(.TICK_CYCLES(4)) uut (.clk_sys, .rst_b,
		.contact_input_raw(raw), .release_in, .s_awaddr(awa),
		.s_awvalid(awv), .s_awready(awr), .s_wdata(wd), .s_wstrb(4'hf),
		.s_wvalid(wv), .s_wready(wrr), .s_bresp(br), .s_bvalid(bv),
		.s_bready(bready), .s_araddr(ara), .s_arvalid(arv),
		.s_arready(arr), .s_rdata(rd), .s_rresp(rr), .s_rvalid(rv),
		.s_rready(rready), .contact_input_state_q(st), .route_q(rt),
		.popup_q(pop), .irq_q(irq));
	initial forever #2.5 clk_sys = ~clk_sys;
	// A hang counts as a mismatch and ends the run.
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			summarize();
		end
	end
	task summarize();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize
	task chk(string n, logic [31:0] e, logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task cs(logic [15:0] e);
		chk("state", {16'h0, e}, {16'h0, st});
	endtask : cs
	task w(int n);
		repeat (n) @(posedge clk_sys);
	endtask : w
	// Bus write; bready stays high, so the answer is taken as it comes.
	task wr(logic [7:0] a, logic [31:0] dt, logic [1:0] er);
		awa <= a;
		wd <= dt;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		do begin
			w(1);
			if (awr) awv <= 1'b0;
			if (wrr) wv <= 1'b0;
		end while (!bv);
		chk("bresp", {30'h0, er}, {30'h0, br});
	endtask : wr
	// Bus read; rready stays high, data is taken at the handshake.
	task rc(logic [7:0] a, logic [31:0] e, logic [1:0] er);
		ara <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		do begin
			w(1);
			if (arr) arv <= 1'b0;
		end while (!rv);
		chk("rdata", e, rd);
		chk("rresp", {30'h0, er}, {30'h0, rr});
	endtask : rc
	task sc_regs();
		rc(8'h00, 32'h0, 2'h0);
		wr(8'h04, 32'h1, 2'h2);
		rc(8'h30, 32'h0, 2'h2);
	endtask : sc_regs
	task sc_open();
		wr(8'h0c, 32'h1, 2'h0);
		lvl[0] <= 1'b1;
		w(8);
		cs(16'h1);
		chk("irq", 32'h1, {31'h0, irq});
		rc(8'h1c, 32'h1, 2'h0);
	endtask : sc_open
	task sc_closed();
		wr(8'h10, 32'h2, 2'h0);
		wr(8'h08, 32'h2, 2'h0);
		w(8);
		cs(16'h3);
		lvl[1] <= 1'b1;
		w(8);
		cs(16'h1);
		rc(8'h1c, 32'h2_0000, 2'h0);
	endtask : sc_closed
	task sc_delay();
		wr(8'h48, 32'h3, 2'h0);
		lvl[2] <= 1'b1;
		w(4);
		lvl[2] <= 1'b0;
		w(20);
		cs(16'h1);
		lvl[2] <= 1'b1;
		w(6);
		cs(16'h1);
		w(14);
		cs(16'h5);
	endtask : sc_delay
	task sc_count();
		wr(8'h8c, 32'hffff, 2'h0);
		lvl[3] <= 1'b1;
		w(8);
		rc(8'h8c, 32'h0, 2'h0);
		rc(8'h80, 32'h1, 2'h0);
	endtask : sc_count
	task sc_popup();
		wr(8'h14, 32'h10, 2'h0);
		lvl[4] <= 1'b1;
		w(8);
		chk("popup", 32'h1, {31'h0, pop});
		rc(8'h24, 32'h10, 2'h0);
	endtask : sc_popup
	// Pulses input 5 so that a latched route is left behind.
	task latch5();
		lvl[5] <= 1'b1;
		w(8);
		lvl[5] <= 1'b0;
		w(8);
	endtask : latch5
	task sc_route();
		wr(8'h18, 32'h20, 2'h0);
		latch5();
		chk("route", 32'h3d, {16'h0, rt});
		wr(8'h00, 32'h2, 2'h0);
		w(2);
		chk("route", 32'h1d, {16'h0, rt});
		wr(8'h00, 32'h74, 2'h0);
		latch5();
		lvl[7] <= 1'b1;
		w(8);
		chk("route", 32'h9d, {16'h0, rt});
		lvl[7] <= 1'b0;
		w(8);
		latch5();
		release_in <= 1'b1;
		w(6);
		chk("route", 32'h1d, {16'h0, rt});
	endtask : sc_route
	// A two-cycle drop in ac mode must not release input 6.
	task sc_ac();
		wr(8'h00, 32'h1, 2'h0);
		lvl[6] <= 1'b1;
		w(8);
		lvl[6] <= 1'b0;
		w(2);
		lvl[6] <= 1'b1;
		w(4);
		cs(16'h5d);
	endtask : sc_ac
	initial begin
		w(12);
		rst_b <= 1'b1;
		w(1);
		wr(8'h20, 32'hffff_ffff, 2'h0);
		sc_regs();
		sc_open();
		sc_closed();
		sc_delay();
		sc_count();
		sc_popup();
		sc_route();
		sc_ac();
		summarize();
	end
endmodule : contact_input_conditioner_tb
